// file: ebc_phaser.sv
/*
 * external bus cycle phase sequencer with register port.
 * assumes the register master is on clk; the wait handshake pin and the link clock
 * come from the external partner and are crossed before use.
 */
module ebc_phaser
    import ebc_pkg::*;
(
    // system clock domain
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // partner clock domain
    input wire logic link_clk,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // external bus pins
    output logic [23:0] ext_addr,
    output logic [15:0] ext_data_o,
    output logic ext_data_oe,
    input wire logic [15:0] ext_data_i,
    output logic rd_n,
    output logic wr_n,
    output logic [EBC_NUM_CS-1:0] cs_n,
    output logic upper_byte_enable_n,
    output logic ale,
    input wire logic ready_pin,
    // reference clock pin
    output logic bus_reference_clock,
    output logic bus_reference_clock_oe
);
    logic [16:0] tcfg_reg [EBC_NUM_CS]; // timing config per chip select
    ebc_req_s req;              // access being run
    logic [1:0] clk_cfg;        // clock output source and driver
    logic [15:0] rdata;         // last read result
    logic [1:0] last_cs;        // select of the previous access
    logic win_chg;              // this access changed window
    ebc_phase_e phase, next_phase;
    logic [EBC_LEN_W-1:0] ph_cnt; // cycles spent in the phase so far
    logic [EBC_LEN_W-1:0] cur_len;
    logic ph_done;
    ebc_tcfg_s cfg;
    logic rdy_link, rdy_sync_lk, rdy_sync_as; // handshake paths
    logic rdy_act;
    logic async_extra;          // one extra wait before an async sample counts

    assign cfg = ebc_tcfg_s'(tcfg_reg[req.cs]);

    // length of a phase in system clock periods
    function automatic logic [EBC_LEN_W-1:0] len_of(input ebc_phase_e p, input ebc_tcfg_s c,
                                                    input logic wc);
        logic [EBC_LEN_W-1:0] l;
        l = '0;
        unique case (p)
            EBC_ADDR: l = EBC_ONE + EBC_LEN_W'(c.ab) + (wc ? EBC_LEN_W'(c.win_ext) : '0);
            EBC_CMDD: l = EBC_LEN_W'(c.cmd);
            EBC_DSET: l = EBC_LEN_W'(c.ds);
            EBC_ACC: l = EBC_ONE + EBC_LEN_W'(c.acc_m1);
            EBC_HOLD: l = EBC_LEN_W'(c.hold);
            EBC_IDLE: l = '0;
        endcase
        return l;
    endfunction : len_of

    // first phase with nonzero length after p; zero length phases are skipped
    function automatic ebc_phase_e step(input ebc_phase_e p, input ebc_tcfg_s c);
        ebc_phase_e n;
        n = EBC_IDLE;
        unique case (p)
            EBC_IDLE: n = EBC_ADDR;
            EBC_ADDR: n = (c.cmd != '0) ? EBC_CMDD : (c.ds ? EBC_DSET : EBC_ACC);
            EBC_CMDD: n = c.ds ? EBC_DSET : EBC_ACC;
            EBC_DSET: n = EBC_ACC;
            EBC_ACC: n = (c.hold != '0) ? EBC_HOLD : EBC_IDLE;
            EBC_HOLD: n = EBC_IDLE;
        endcase
        return n;
    endfunction : step

    // handshake seen by the partner's clock, then crossed into ours
    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
            rdy_link <= 1'b0;
        else
            rdy_link <= ready_pin;
    end

    ebc_sync u_sync_lk (
        .clk(clk),
        .rst_n(rst_n),
        .din(rdy_link),
        .dout(rdy_sync_lk)
    );

    // asynchronous use: raw pin straight into two flops
    ebc_sync u_sync_as (
        .clk(clk),
        .rst_n(rst_n),
        .din(ready_pin),
        .dout(rdy_sync_as)
    );

    // polarity applied after the crossing
    assign rdy_act = (cfg.rdy_async ? rdy_sync_as : rdy_sync_lk) == cfg.rdy_pol;

    assign cur_len = len_of(phase, cfg, win_chg);
    assign ph_done = (phase != EBC_IDLE) && (ph_cnt + EBC_ONE >= cur_len);

    // phase sequencing, access end decided by the handshake when enabled
    always_comb
    begin
        next_phase = phase;
        if (phase == EBC_IDLE)
            next_phase = EBC_IDLE; // start handled by the command write
        else if (ph_done)
        begin
            // the forced extra wait belongs to the async path only
            if (phase == EBC_ACC && cfg.rdy_en && (!rdy_act || (cfg.rdy_async && async_extra)))
                next_phase = EBC_ACC; // wait state
            else
                next_phase = step(phase, cfg);
        end
    end

    // phase register and counter
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase <= EBC_IDLE;
            ph_cnt <= '0;
        end
        else if (ce)
        begin
            if (phase == EBC_IDLE && reg_wr && reg_addr == EBC_OFS_CMD)
            begin
                phase <= EBC_ADDR;
                ph_cnt <= '0;
            end
            else if (next_phase != phase)
            begin
                phase <= next_phase;
                ph_cnt <= '0;
            end
            else if (phase != EBC_IDLE && !ph_done)
                ph_cnt <= ph_cnt + EBC_ONE;
        end
    end

    // async handshake costs one extra wait over synchronous use
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            async_extra <= 1'b0;
        else if (ce)
        begin
            if (phase != EBC_ACC)
                async_extra <= 1'b1;
            else if (ph_done && cfg.rdy_async)
                async_extra <= 1'b0;
            else if (!cfg.rdy_async)
                async_extra <= 1'b0;
        end
    end

    // window tracking for the setup extension
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            last_cs <= '0;
            win_chg <= 1'b0;
        end
        else if (ce && phase == EBC_IDLE && reg_wr && reg_addr == EBC_OFS_CMD)
        begin
            win_chg <= reg_wdata[EBC_C_CS +: 2] != last_cs;
            last_cs <= reg_wdata[EBC_C_CS +: 2];
        end
    end

    // register writes; the command is ignored while a cycle runs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < EBC_NUM_CS; i++)
                tcfg_reg[i] <= EBC_TCFG_RST;
            req <= '0;
            clk_cfg <= '0;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr[7:4] == EBC_OFS_TCFG0[7:4] && reg_addr[1:0] == 2'h0)
                tcfg_reg[reg_addr[3:EBC_TCFG_IDX_LSB]] <= reg_wdata[16:0];
            else if (reg_addr == EBC_OFS_ADDR && phase == EBC_IDLE)
                req.addr <= reg_wdata[23:0];
            else if (reg_addr == EBC_OFS_WDATA && phase == EBC_IDLE)
                req.wdata <= reg_wdata[15:0];
            else if (reg_addr == EBC_OFS_CMD && phase == EBC_IDLE)
            begin
                req.read <= reg_wdata[EBC_C_READ];
                req.cs <= reg_wdata[EBC_C_CS +: 2];
                req.ube <= reg_wdata[EBC_C_UBE];
            end
            else if (reg_addr == EBC_OFS_REFCLK)
                clk_cfg <= reg_wdata[1:0];
        end
    end

    // read data taken on the edge that ends the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (ce && phase == EBC_ACC && next_phase != EBC_ACC && req.read)
            rdata <= ext_data_i;
    end

    // register read port, one cycle latency, unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (ce)
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                if (reg_addr[7:4] == EBC_OFS_TCFG0[7:4] && reg_addr[1:0] == 2'h0)
                    reg_rdata <= {15'h0000, tcfg_reg[reg_addr[3:EBC_TCFG_IDX_LSB]]};
                else if (reg_addr == EBC_OFS_ADDR)
                    reg_rdata <= {8'h00, req.addr};
                else if (reg_addr == EBC_OFS_WDATA)
                    reg_rdata <= {16'h0000, req.wdata};
                else if (reg_addr == EBC_OFS_CMD)
                    reg_rdata <= {28'h0000000, req.ube, req.cs, req.read};
                else if (reg_addr == EBC_OFS_STATUS)
                    reg_rdata <= {29'h00000000, win_chg, rdy_act, phase != EBC_IDLE};
                else if (reg_addr == EBC_OFS_RDATA)
                    reg_rdata <= {16'h0000, rdata};
                else if (reg_addr == EBC_OFS_REFCLK)
                    reg_rdata <= {30'h00000000, clk_cfg};
            end
        end
    end

    // bus pins, all from flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ext_addr <= '0;
            ext_data_o <= '0;
            ext_data_oe <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n <= '1;
            upper_byte_enable_n <= 1'b1;
            ale <= 1'b0;
        end
        else if (ce)
        begin
            ext_addr <= req.addr; // held through the hold phase
            upper_byte_enable_n <= !req.ube;
            ale <= next_phase == EBC_ADDR || (phase == EBC_IDLE && reg_wr && reg_addr == EBC_OFS_CMD);
            cs_n <= '1;
            if (next_phase != EBC_IDLE || phase == EBC_IDLE && reg_wr && reg_addr == EBC_OFS_CMD)
                cs_n[(phase == EBC_IDLE) ? reg_wdata[EBC_C_CS +: 2] : req.cs] <= 1'b0;
            // strobe from the end of command delay until hold begins
            rd_n <= !(next_phase inside {EBC_DSET, EBC_ACC} && req.read);
            wr_n <= !(next_phase inside {EBC_DSET, EBC_ACC} && !req.read);
            // mux mode: address on data bus in setup cycles after the first, then turnaround for reads
            if (cfg.mux && next_phase == EBC_ADDR)
            begin
                ext_data_o <= req.addr[15:0];
                ext_data_oe <= 1'b1;
            end
            else
            begin
                ext_data_o <= req.wdata;
                ext_data_oe <= !req.read && (next_phase == EBC_DSET || next_phase == EBC_ACC
                               || next_phase == EBC_HOLD);
            end
        end
    end

    ebc_bus_reference_clock u_bus_reference_clock (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .src_sys(clk_cfg[EBC_K_SRC]),
        .hs_en(clk_cfg[EBC_K_HS]),
        .clock_output_pin_signal(bus_reference_clock),
        .clock_output_pin_oe(bus_reference_clock_oe)
    );

    // checks, all in the system clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic leaving;
    assign leaving = ce && phase != EBC_IDLE && next_phase != phase;

    property p_order;
        leaving |-> (phase == EBC_ADDR && next_phase inside {EBC_CMDD, EBC_DSET, EBC_ACC})
            || (phase == EBC_CMDD && next_phase inside {EBC_DSET, EBC_ACC})
            || (phase == EBC_DSET && next_phase == EBC_ACC)
            || (phase == EBC_ACC && next_phase inside {EBC_HOLD, EBC_IDLE})
            || (phase == EBC_HOLD && next_phase == EBC_IDLE);
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");

    property p_cmd_len;
        (leaving && phase == EBC_CMDD) |-> ph_cnt + EBC_ONE == EBC_LEN_W'(cfg.cmd);
    endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("command delay length wrong");

    property p_acc_len;
        (leaving && phase == EBC_ACC) |-> ph_cnt + EBC_ONE >= EBC_ONE + EBC_LEN_W'(cfg.acc_m1);
    endproperty
    a_acc_len: assert property (p_acc_len) else $error("access ended early");

    property p_ab_len;
        (leaving && phase == EBC_ADDR) |-> ph_cnt + EBC_ONE == EBC_ONE + EBC_LEN_W'(cfg.ab)
            + (win_chg ? EBC_LEN_W'(cfg.win_ext) : '0);
    endproperty
    a_ab_len: assert property (p_ab_len) else $error("address setup length wrong");

    property p_ds_len;
        (leaving && phase == EBC_DSET) |-> ph_cnt == '0 && cfg.ds;
    endproperty
    a_ds_len: assert property (p_ds_len) else $error("data setup length wrong");

    property p_hold_len;
        (leaving && phase == EBC_HOLD) |-> ph_cnt + EBC_ONE == EBC_LEN_W'(cfg.hold);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold length wrong");

    property p_wait;
        (ce && phase == EBC_ACC && ph_done && cfg.rdy_en && !rdy_act) |=> phase == EBC_ACC;
    endproperty
    a_wait: assert property (p_wait) else $error("inactive handshake did not wait");

    property p_strobe;
        (ce && phase == EBC_ACC && !leaving) |=> (rd_n != wr_n);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not held in access");

    property p_capture;
        (leaving && phase == EBC_ACC && req.read) |=> rdata == $past(ext_data_i);
    endproperty
    a_capture: assert property (p_capture) else $error("read data not captured");

    c_read: cover property (leaving && phase == EBC_ACC && req.read);
    c_write: cover property (leaving && phase == EBC_ACC && !req.read);
    c_wait: cover property (ce && phase == EBC_ACC && ph_done && next_phase == EBC_ACC);
    c_window: cover property (leaving && phase == EBC_ADDR && win_chg);
endmodule : ebc_phaser

// file: ebc_pkg.sv
/*
 * constants, field layouts and carrier types of the external bus cycle phaser.
 * assumes one system clock at 50 MHz; every phase length is counted in its periods.
 */
//
// Contract
// - five phases run in fixed order
// - phase lengths programmable per chip select
// - access lasts 1..32, wait handshake may stretch
// - address setup 1..2, plus 0..3 on window change
// - data setup or turnaround lasts 0 or 1
// - hold address and data 0..3 periods
// - reference clock from system clock, fast driver
// - all lengths counted in system clock periods
// - read data captured on strobe release edge
// - asynchronous handshake synchronised, costs extra wait
// - inactive handshake inserts wait, active ends cycle
package ebc_pkg;

    // register byte offsets
    localparam logic [7:0] EBC_OFS_TCFG0 = 8'h00; // four timing configs, one per select
    localparam logic [7:0] EBC_OFS_ADDR = 8'h10;
    localparam logic [7:0] EBC_OFS_WDATA = 8'h14;
    localparam logic [7:0] EBC_OFS_CMD = 8'h18; // write starts a cycle
    localparam logic [7:0] EBC_OFS_STATUS = 8'h1c;
    localparam logic [7:0] EBC_OFS_RDATA = 8'h20;
    localparam logic [7:0] EBC_OFS_REFCLK = 8'h24;
    localparam int EBC_NUM_CS = 4;
    localparam logic [1:0] EBC_TCFG_IDX_LSB = 2'h2; // word index bits of the config offsets

    // timing config field positions
    localparam int EBC_F_AB = 0;       // address setup base: 0 -> 1, 1 -> 2
    localparam int EBC_F_CMD = 1;      // command delay, 2 bits
    localparam int EBC_F_DS = 3;       // data setup / turnaround, 1 bit
    localparam int EBC_F_ACC = 4;      // access length minus one, 5 bits
    localparam int EBC_F_HOLD = 9;     // hold, 2 bits
    localparam int EBC_F_WIN = 11;     // window change extension, 2 bits
    localparam int EBC_F_RDYEN = 13;
    localparam int EBC_F_RDYASY = 14;
    localparam int EBC_F_RDYPOL = 15;  // 1: handshake active high
    localparam int EBC_F_MUX = 16;     // multiplexed address/data bus
    localparam logic [16:0] EBC_TCFG_RST = 17'h00000; // fastest timing after reset

    // command register fields
    localparam int EBC_C_READ = 0;
    localparam int EBC_C_CS = 1;       // 2 bits
    localparam int EBC_C_UBE = 3;
    // clock output register fields
    localparam int EBC_K_SRC = 0;      // 1: system clock is the pin source
    localparam int EBC_K_HS = 1;       // high speed driver enable

    localparam int EBC_CLK_MHZ = 50;
    localparam int EBC_LEN_W = 6;      // wide enough for 32 and for 5
    localparam logic [EBC_LEN_W-1:0] EBC_ONE = 6'h01;

    typedef enum {EBC_IDLE, EBC_ADDR, EBC_CMDD, EBC_DSET, EBC_ACC, EBC_HOLD} ebc_phase_e;

    // one chip select timing config, unpacked from the register
    typedef struct packed {
        logic mux;
        logic rdy_pol;
        logic rdy_async;
        logic rdy_en;
        logic [1:0] win_ext;
        logic [1:0] hold;
        logic [4:0] acc_m1;
        logic ds;
        logic [1:0] cmd;
        logic ab;
    } ebc_tcfg_s;

    // one pending access
    typedef struct packed {
        logic read;
        logic [1:0] cs;
        logic ube;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebc_req_s;

endpackage : ebc_pkg

// file: ebc_sync.sv
/*
 * two flop level synchroniser.
 * assumes the input is a level from another domain or a pin; runs free of the enable.
 */
module ebc_sync
    import ebc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic meta; // first stage, read only by the second

    // plain two stage capture
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : ebc_sync

// file: ebc_bus_reference_clock.sv
/*
 * reference clock pin driver: gates the system clock onto the clock output pin.
 * assumes the enable bits come from flops on the same clock.
 */
module ebc_bus_reference_clock
    import ebc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // selection
    input wire logic src_sys,
    input wire logic hs_en,
    // pin
    output logic clock_output_pin_signal,
    output logic clock_output_pin_oe
);
    logic gate_en; // changes only while clk is low, so the gate never cuts a high pulse

    // enable taken on the falling edge
    always_ff @(negedge clk)
    begin
        if (!rst_n)
            gate_en <= 1'b0;
        else if (ce)
            gate_en <= src_sys && hs_en;
    end

    assign clock_output_pin_signal = clk && gate_en;
    assign clock_output_pin_oe = hs_en;
endmodule : ebc_bus_reference_clock

// file: ebc_mem_model.sv
/*
 * far side model: external memory or peripheral with a wait handshake.
 * assumes strobes are active low and the bench sets handshake delay and polarity.
 */
module ebc_mem_model
    import ebc_pkg::*;
(
    // clocks
    input wire logic clk,
    input wire logic link_clk,
    // bus pins
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] ext_data_o,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [15:0] ext_data_i,
    output logic ready_pin,
    // bench control and view
    input wire logic [7:0] ready_dly,
    input wire logic ready_pol,
    output logic [15:0] last_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] wait_cnt = 8'h00; // link clocks under the strobe
    logic strobe; // any command active

    assign strobe = !rd_n || !wr_n;
    // data only valid under the read strobe; inverse after so a late capture shows
    assign ext_data_i = (ext_addr[15:0] ^ 16'ha5a5) ^ {16{rd_n}};

    // count link clocks under the strobe; capped below 8'hff so that value means never
    always @(posedge link_clk)
    begin
        if (!strobe)
            wait_cnt <= 8'h00;
        else if (wait_cnt != 8'hfe)
            wait_cnt <= wait_cnt + 8'h01;
    end

    // handshake active once the delay has run, dropped with the strobe
    assign ready_pin = (strobe && wait_cnt >= ready_dly) ? ready_pol : !ready_pol;

    // keep the last word seen under the write strobe
    always @(posedge clk)
        if (!wr_n)
            last_wdata <= ext_data_o;
endmodule : ebc_mem_model

// file: external_bus_cycle_phasing_test.sv
/*
 * self-checking bench of the bus cycle phaser: random timing configs, handshake, clock pin.
 * assumes the memory model is compiled first; ce drops once to show a frozen write.
 */
module external_bus_cycle_phasing_test
    import ebc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [23:0] ext_addr;
    logic [15:0] ext_data_o, ext_data_i, last_wdata;
    logic ext_data_oe, rd_n, wr_n, upper_byte_enable_n, ale, ready_pin;
    logic [EBC_NUM_CS-1:0] cs_n;
    logic bus_reference_clock, bus_reference_clock_oe;
    logic [7:0] ready_dly = 8'hff; // never answer unless a test asks
    logic ready_pol = 1'b1;
    int failures = 0;
    int check_count = 0;
    int cs_len, ale_len, pre_len, str_len, post_len; // phase lengths seen at the pins
    logic [3:0] cs_seen;
    logic ube_seen;
    logic [1:0] prev_cs = 2'h0; // first access compares against select 0

    always #10 clk = ~clk;
    // link clock offset so it never lines up with clk
    initial
    begin
        #7;
        forever #32 link_clk = ~link_clk;
    end

    ebc_phaser i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
        .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i), .rd_n(rd_n), .wr_n(wr_n),
        .cs_n(cs_n), .upper_byte_enable_n(upper_byte_enable_n), .ale(ale),
        .ready_pin(ready_pin), .bus_reference_clock(bus_reference_clock),
        .bus_reference_clock_oe(bus_reference_clock_oe));

    ebc_mem_model i_mem (.clk(clk), .link_clk(link_clk), .ext_addr(ext_addr),
        .ext_data_o(ext_data_o), .rd_n(rd_n), .wr_n(wr_n), .ext_data_i(ext_data_i),
        .ready_pin(ready_pin), .ready_dly(ready_dly), .ready_pol(ready_pol),
        .last_wdata(last_wdata));

    // pin monitor: counts cycles of each phase while a select is low
    always @(posedge clk)
    begin
        if (rst_n && !(&cs_n))
        begin
            cs_len++;
            cs_seen = cs_n;
            ube_seen = upper_byte_enable_n;
            if (ale)
                ale_len++;
            if (!rd_n || !wr_n)
                str_len++;
            else if (str_len == 0)
                pre_len++;
            else
                post_len++;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : reg_read

    // one full bus access, then compare the phase lengths against the config; access and whole cycle only when the handshake is off
    task automatic run_cycle(input logic rd, input logic [1:0] cs, input logic ube,
                             input ebc_tcfg_s c, input logic [23:0] a, input logic [15:0] wd);
        int ab;
        int n;
        logic [31:0] d;
        reg_write({4'h0, cs, 2'h0}, {15'h0, c});
        reg_write(EBC_OFS_ADDR, {8'h00, a});
        reg_write(EBC_OFS_WDATA, {16'h0000, wd});
        cs_len = 0;
        ale_len = 0;
        pre_len = 0;
        str_len = 0;
        post_len = 0;
        reg_write(EBC_OFS_CMD, {28'h0, ube, cs, rd});
        n = 0;
        while ((cs_len == 0 || !(&cs_n)) && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check("cycle ends", n < 400, 1'b1);
        ab = 1 + c.ab + ((cs != prev_cs) ? c.win_ext : 0);
        prev_cs = cs;
        check("addr setup", ale_len, ab);
        check("before strobe", pre_len, ab + c.cmd);
        check("hold", post_len, c.hold);
        check("select one-hot", cs_seen, 4'(~(4'h1 << cs)));
        check("upper byte", ube_seen, !ube);
        if (!c.rdy_en)
        begin
            check("access", str_len, c.ds + c.acc_m1 + 1);
            check("whole cycle", cs_len, ab + c.cmd + c.ds + c.acc_m1 + 1 + c.hold);
        end
        if (rd)
        begin
            reg_read(EBC_OFS_RDATA, d);
            check("read data", d, {16'h0, a[15:0] ^ 16'ha5a5});
        end
        else
            check("write data", last_wdata, wd);
    endtask : run_cycle

    initial
    begin
        #200us;
        failures++;
        stop_test();
    end

    initial
    begin
        ebc_tcfg_s c;
        logic [31:0] d;
        logic [31:0] w;
        void'($urandom(32'h2326));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("idle pins", {cs_n, rd_n, wr_n, ale, ext_data_oe}, 8'hfc);
        // config registers keep 17 bits, unmapped reads give zero
        for (int i = 0; i < EBC_NUM_CS; i++)
        begin
            w = $urandom;
            reg_write(8'(i * 4), w);
            reg_read(8'(i * 4), d);
            check("config readback", d, {15'h0, w[16:0]});
        end
        reg_read(8'h30, d);
        check("unmapped", d, 32'h0);
        // random timings with the two extreme configs first
        for (int i = 0; i < 24; i++)
        begin
            c = ebc_tcfg_s'(17'($urandom));
            if (i == 0)
                c = '0;
            if (i == 1)
                c = ebc_tcfg_s'(17'h1ffff);
            c.rdy_en = 1'b0;
            run_cycle(1'($urandom), 2'($urandom), 1'($urandom), c, 24'($urandom),
                      16'($urandom));
        end
        // handshake: async costs a wait, slow partner stretches, both polarities
        c = '0;
        c.rdy_en = 1'b1;
        c.rdy_async = 1'b1;
        c.rdy_pol = 1'b1;
        ready_dly = 8'h00;
        run_cycle(1'b1, prev_cs, 1'b0, c, 24'h001234, 16'h0);
        check("async extra wait", str_len >= 2, 1'b1);
        for (int p = 0; p < 2; p++)
        begin
            c.rdy_async = 1'b0;
            c.rdy_pol = p[0];
            ready_pol = p[0];
            ready_dly = 8'h04;
            run_cycle(1'b0, prev_cs, 1'b1, c, 24'h00beef, 16'($urandom));
            check("stretched access", str_len >= 9, 1'b1);
        end
        // enable low: a register write must not land
        ce <= 1'b0;
        reg_write(EBC_OFS_ADDR, 32'h00123456);
        ce <= 1'b1;
        reg_read(EBC_OFS_ADDR, d);
        check("frozen write", d, 32'h0000beef);
        ready_dly = 8'hff;
        // reference clock pin follows the system clock when selected
        reg_write(EBC_OFS_REFCLK, 32'h3);
        repeat (3) @(posedge clk);
        #5;
        check("ref clock high", bus_reference_clock, 1'b1);
        check("ref clock driver", bus_reference_clock_oe, 1'b1);
        @(negedge clk);
        #5;
        check("ref clock low", bus_reference_clock, 1'b0);
        reg_write(EBC_OFS_REFCLK, 32'h0);
        repeat (3) @(posedge clk);
        #5;
        check("ref clock off", {bus_reference_clock, bus_reference_clock_oe}, 2'h0);
        stop_test();
    end
endmodule : external_bus_cycle_phasing_test
